// [inc/pro_filt_if.sv]
// carrier between the port top and its input filter
interface pro_filt_if;
	logic [7:0] raw;    // synchronised opto levels, active low
	logic [7:0] strap;  // per-bit filter select
	logic [7:0] clean;  // filtered levels, active low

	modport src  (output raw, output strap, input clean);
	modport filt (input raw, input strap, output clean);
endinterface

// [inc/pro_pkg.sv]
// shared constants and state types for the relay and opto port block
package pro_pkg;
	// clock rate and the input filter interval
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned DEBOUNCE_US     = 1000;
	localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
	localparam int unsigned DB_CW           = 20;
	// io offsets within the two-byte window
	localparam logic        OFS_RELAY       = 1'b0;
	localparam logic        OFS_GATE        = 1'b1;
	localparam int unsigned GATE_EN_BIT     = 0;
	// configuration header dword indices
	localparam logic [5:0]  CFG_IDS         = 6'h00;
	localparam logic [5:0]  CFG_BAR         = 6'h06;
	localparam logic [5:0]  CFG_SUBIDS      = 6'h0B;
	localparam logic [5:0]  CFG_INTLINE     = 6'h0F;
	localparam logic [1:0]  BAR_IO_FLAGS    = 2'h1;
	// reset values
	localparam logic [7:0]  LATCH_RST       = 8'h00;
	localparam logic [7:0]  OPTO_RST        = 8'hFF;
	localparam logic [7:0]  STRAP_RST       = 8'h00;
	localparam logic [7:0]  SENSE_RST       = 8'h00;

	// whole state of the top module
	typedef struct packed {
		logic [7:0]      latch;      // relay command latch
		logic            enable;     // relay driver gate bit
		logic [7:0]      drive;      // registered coil drive
		logic [2:0][7:0] sense_sy;   // relay position synchroniser
		logic [7:0]      sense;      // agreed relay positions
		logic [2:0][7:0] opto_sy;    // opto input synchroniser
		logic [7:0]      opto;       // agreed opto levels
		logic [2:0][7:0] strap_sy;   // strap synchroniser
		logic [7:0]      strap;      // agreed strap levels
		logic [31:2]     bar_base;   // io base address
		logic [7:0]      int_line;   // interrupt line byte
		logic [7:0]      io_rdata;   // io read answer
		logic            io_ack;     // io cycle answer
		logic [31:0]     cfg_rdata;  // config read answer
		logic            cfg_ack;    // config cycle answer
	} pro_top_t;

	// whole state of the input filter
	typedef struct packed {
		logic [7:0][DB_CW-1:0] cnt;  // per-bit stability counters
		logic [7:0]            clean; // filtered levels
	} pro_filt_t;
endpackage

// [rtl/pro_filter.sv]
// per-bit debounce filter with strap bypass for the opto inputs
module pro_filter #(
	parameter logic [pro_pkg::DB_CW-1:0] DEBOUNCE_CYCLES = pro_pkg::DB_CW'(pro_pkg::DEBOUNCE_CYC)
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	pro_filt_if.filt   fi
);
	pro_pkg::pro_filt_t st;       // registered state
	pro_pkg::pro_filt_t next_st;  // next state

	// filter step per bit
	always_comb begin
		next_st = st;
		for (int i = 0; i < 8; i++) begin
			if (!fi.strap[i]) begin
				// bypass: follow the level directly
				next_st.clean[i] = fi.raw[i];
				next_st.cnt[i]   = '0;
			end else if (fi.raw[i] == st.clean[i]) begin
				// level matches output: restart the interval
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] >= DEBOUNCE_CYCLES - 1'b1) begin
				next_st.clean[i] = fi.raw[i];
				next_st.cnt[i]   = '0;
			end else begin
				// still counting a differing level
				next_st.cnt[i] = st.cnt[i] + 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.cnt   <= '0;
			st.clean <= pro_pkg::OPTO_RST;
		end else begin
			st <= next_st;
		end
	end

	// filtered output straight from the register
	assign fi.clean = st.clean;
endmodule

// [rtl/pro_port.sv]
// relay output and opto input port with io and config access
//
// Function
// - relays rest normally-closed until commanded and enabled
// - offset zero write latches eight relay commands
// - commands reach drivers only with enable bit
// - enable zero forces all relays off
// - reset clears the enable bit
// - offset zero read returns relay positions
// - offset one read returns opto levels
// - two byte locations, read/write differ
// - per-input debounce selected by strap
// - config header exposes ids, base, line
// - strap n enables debounce on bit n
module pro_port #(
	parameter logic [15:0]               VENDOR_CODE     = 16'h1234, // arbitrary value
	parameter logic [15:0]               DEVICE_CODE     = 16'h0001, // arbitrary value
	parameter logic [15:0]               SUBVENDOR_CODE  = 16'h1234, // arbitrary value
	parameter logic [15:0]               SUBSYSTEM_CODE  = 16'h0002, // arbitrary value
	parameter logic [pro_pkg::DB_CW-1:0] DEBOUNCE_CYCLES = pro_pkg::DB_CW'(pro_pkg::DEBOUNCE_CYC)
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] io_addr,
	input  wire logic        io_rd,
	input  wire logic        io_wr,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_ack,
	input  wire logic [5:0]  cfg_reg,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_ack,
	input  wire logic [7:0]  relay_sense,
	input  wire logic [7:0]  opto_in_n,
	input  wire logic [7:0]  debounce_select_straps,
	output logic      [7:0]  relay_drive
);
	pro_pkg::pro_top_t st;       // registered state
	pro_pkg::pro_top_t next_st;  // next state
	pro_filt_if        fif ();   // link to the input filter
	logic              io_hit;   // address falls in the window
	logic              io_ofs;   // byte offset within the window

	// per-bit agreement of the last two synchroniser stages
	function automatic logic [7:0] agree(input logic [7:0] s2, input logic [7:0] s3,
			input logic [7:0] old);
		agree = (s3 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
	endfunction

	assign io_hit = (io_addr[31:1] == {st.bar_base, 1'b0});
	assign io_ofs = io_addr[0];

	// filter hookup
	assign fif.raw   = st.opto;
	assign fif.strap = st.strap;

	pro_filter #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_filter (
		.clk   (clk),
		.rst_n (rst_n),
		.fi    (fif)
	);

	// next-state logic
	always_comb begin
		next_st = st;
		// three-stage synchronisers for the pins
		next_st.sense_sy = {st.sense_sy[1:0], relay_sense};
		next_st.opto_sy  = {st.opto_sy[1:0], opto_in_n};
		next_st.strap_sy = {st.strap_sy[1:0], debounce_select_straps};
		next_st.sense    = agree(st.sense_sy[1], st.sense_sy[2], st.sense);
		next_st.opto     = agree(st.opto_sy[1], st.opto_sy[2], st.opto);
		// strap bit n for input n
		next_st.strap    = agree(st.strap_sy[1], st.strap_sy[2], st.strap);
		// answers stand one cycle
		next_st.io_ack   = 1'b0;
		next_st.cfg_ack  = 1'b0;

		// io write and read cycles
		if (io_wr && io_hit) begin
			next_st.io_ack = 1'b1;
			if (io_ofs == pro_pkg::OFS_RELAY) begin
				next_st.latch = io_wdata;
			end else begin
				next_st.enable = io_wdata[pro_pkg::GATE_EN_BIT];
			end
		end else if (io_rd && io_hit) begin
			next_st.io_ack = 1'b1;
			if (io_ofs == pro_pkg::OFS_RELAY) begin
				next_st.io_rdata = st.sense;
			end else begin
				next_st.io_rdata = fif.clean;
			end
		end

		// config header cycles
		if (cfg_wr) begin
			next_st.cfg_ack = 1'b1;
			case (cfg_reg)
				pro_pkg::CFG_BAR: begin
					next_st.bar_base = cfg_wdata[31:2];
				end
				pro_pkg::CFG_INTLINE: begin
					next_st.int_line = cfg_wdata[7:0];
				end
				// id words are read only
				default: begin
					next_st.cfg_ack = 1'b1;
				end
			endcase
		end else if (cfg_rd) begin
			next_st.cfg_ack = 1'b1;
			case (cfg_reg)
				pro_pkg::CFG_IDS: begin
					next_st.cfg_rdata = {DEVICE_CODE, VENDOR_CODE};
				end
				pro_pkg::CFG_BAR: begin
					next_st.cfg_rdata = {st.bar_base, pro_pkg::BAR_IO_FLAGS};
				end
				pro_pkg::CFG_SUBIDS: begin
					next_st.cfg_rdata = {SUBSYSTEM_CODE, SUBVENDOR_CODE};
				end
				pro_pkg::CFG_INTLINE: begin
					next_st.cfg_rdata = {24'h000000, st.int_line};
				end
				// other header words read zero
				default: begin
					next_st.cfg_rdata = 32'h00000000;
				end
			endcase
		end

		next_st.drive = st.enable ? st.latch : 8'h00;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.latch     <= pro_pkg::LATCH_RST;
			st.enable    <= 1'b0;
			st.drive     <= 8'h00;
			st.sense_sy  <= '0;
			st.sense     <= pro_pkg::SENSE_RST;
			st.opto_sy   <= {3{pro_pkg::OPTO_RST}};
			st.opto      <= pro_pkg::OPTO_RST;
			st.strap_sy  <= '0;
			st.strap     <= pro_pkg::STRAP_RST;
			st.bar_base  <= '0;
			st.int_line  <= 8'h00;
			st.io_rdata  <= 8'h00;
			st.io_ack    <= 1'b0;
			st.cfg_rdata <= 32'h00000000;
			st.cfg_ack   <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the register
	assign io_rdata    = st.io_rdata;
	assign io_ack      = st.io_ack;
	assign cfg_rdata   = st.cfg_rdata;
	assign cfg_ack     = st.cfg_ack;
	assign relay_drive = st.drive;
endmodule

// [tb/pro_field.sv]
// relay contact model: position follows the coil drive after a pull-in delay
module pro_field (
	input  wire logic       clk,
	input  wire logic [7:0] relay_drive,
	output logic      [7:0] relay_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] arm = 8'h00; // contact in flight
	// contacts settle two clocks after the coil changes
	always @(posedge clk) begin
		arm <= relay_drive;
		relay_sense <= arm;
	end
endmodule

// [tb/pro_port_assertions.sv]
// concurrent checks on the pins of the relay and opto port
module pro_port_assertions (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        io_rd,
	input wire logic        io_wr,
	input wire logic [31:0] io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_ack,
	input wire logic [5:0]  cfg_reg,
	input wire logic        cfg_rd,
	input wire logic        cfg_wr,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_ack,
	input wire logic [7:0]  relay_drive
);
	timeunit 1ns;
	timeprecision 1ns;
	// single clock domain, reset disables every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_drive_cause: assert property (!$stable(relay_drive) |-> $past(io_wr, 2))
		else $error("relay drive moved with no write two cycles before");
	a_gate_off: assert property (io_ack && $past(io_wr && io_addr[0] && !io_wdata[0])
		|=> relay_drive == 8'h00) else $error("relay drive not off after gate clear");
	a_io_ack_cause: assert property (io_ack |-> $past(io_rd || io_wr))
		else $error("io answer with no request");
	a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata))
		else $error("io read data moved with no read");
	a_cfg_answer: assert property ((cfg_rd || cfg_wr) |=> cfg_ack)
		else $error("config cycle not answered next cycle");
	a_cfg_cause: assert property (cfg_ack |-> $past(cfg_rd || cfg_wr))
		else $error("config answer with no request");
	a_cfg_hold: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
		else $error("config read data moved with no read");
	a_id_word: assert property (cfg_ack && $past(cfg_rd && cfg_reg == 6'h00)
		|-> cfg_rdata == 32'h00011234) else $error("identity word wrong");
	a_bar_flags: assert property (cfg_ack && $past(cfg_rd && cfg_reg == 6'h06)
		|-> cfg_rdata[1:0] == 2'h1) else $error("base register flags wrong");
	a_reset_off: assert property (!$past(rst_n) |-> relay_drive == 8'h00)
		else $error("relay drive on right after reset");
endmodule

bind pro_port pro_port_assertions u_chk (.*);

// [tb/pro_port_tb_top.sv]
// self-checking bench for the relay and opto port
module pro_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, io_rd = 1'b0, io_wr = 1'b0;
	logic        cfg_rd = 1'b0, cfg_wr = 1'b0, io_ack, cfg_ack;
	logic [31:0] io_addr = 32'h0, cfg_wdata = 32'h0, cfg_rdata, base = 32'h0;
	logic [7:0]  io_wdata = 8'h00, opto_in_n = 8'hFF, debounce_select_straps = 8'h00;
	logic [7:0]  io_rdata, relay_sense, relay_drive, v;
	logic [5:0]  cfg_reg = 6'h00;
	logic [8:0]  io_q[$], n9;  // bit 8 marks a read to compare
	logic [32:0] cfg_q[$], n33; // bit 32 marks a read to compare
	int          num_errors = 0, comparisons = 0;
	// free running 100 MHz clock
	always #5 clk = ~clk;
	pro_port #(.DEBOUNCE_CYCLES(20'h8)) dut (.clk, .rst_n, .io_addr, .io_rd, .io_wr,
		.io_wdata, .io_rdata, .io_ack, .cfg_reg, .cfg_rd, .cfg_wr, .cfg_wdata, .cfg_rdata,
		.cfg_ack, .relay_sense, .opto_in_n, .debounce_select_straps, .relay_drive);
	pro_field fld (.clk, .relay_drive, .relay_sense);
	// mismatch report shared by the compare tasks
	task automatic miss(input logic [31:0] got, input logic [31:0] exp);
		num_errors++;
		$display("[ERR] %0t got %h exp %h", $time, got, exp);
	endtask
	// counts and unexpected answers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) miss(got, exp);
	endtask
	// relay coil drive against the expected pattern
	task automatic chk_drive(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) miss({24'h000000, got}, {24'h000000, exp});
	endtask
	// io read byte against the noted byte
	task automatic chk_io(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) miss({24'h000000, got}, {24'h000000, exp});
	endtask
	// config read word against the noted word
	task automatic chk_cfg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) miss(got, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one io cycle; a note is kept only when the address hits the window
	task automatic io(input logic w, input logic [31:0] a, input logic [7:0] d,
		input logic [8:0] e);
		wt(1);
		io_addr = a;
		io_wr = w;
		io_rd = !w;
		io_wdata = d;
		if (a[31:1] == base[31:1]) io_q.push_back(e);
		wt(1);
		io_wr = 1'b0;
		io_rd = 1'b0;
	endtask
	// one config cycle; every index is answered
	task automatic cfg(input logic w, input logic [5:0] r, input logic [31:0] d,
		input logic [32:0] e);
		wt(1);
		cfg_reg = r;
		cfg_wr = w;
		cfg_rd = !w;
		cfg_wdata = d;
		cfg_q.push_back(e);
		wt(1);
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
	endtask
	task automatic close_out();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// answers are matched against the oldest note on the settled half cycle
	always @(negedge clk) begin
		if (io_ack === 1'b1) begin
			if (io_q.size() == 0) chk(32'h1, 32'h0);
			else begin
				n9 = io_q.pop_front();
				if (n9[8]) chk_io(io_rdata, n9[7:0]);
			end
		end
		if (cfg_ack === 1'b1) begin
			if (cfg_q.size() == 0) chk(32'h1, 32'h0);
			else begin
				n33 = cfg_q.pop_front();
				if (n33[32]) chk_cfg(cfg_rdata, n33[31:0]);
			end
		end
	end
	// watchdog well beyond the 150 or so cycles the run needs
	initial begin
		#100us;
		num_errors++;
		close_out();
	end
	// main sequence
	initial begin
		v = 8'($urandom(31));
		wt(20);
		rst_n = 1'b1;
		chk_drive(relay_drive, 8'h00);
		io(1'b1, 32'h0, 8'hA5, 9'h0);
		wt(4);
		chk_drive(relay_drive, 8'h00);
		io(1'b0, 32'h0, 8'h00, 9'h100);
		io(1'b1, 32'h1, 8'h01, 9'h0);
		wt(2);
		chk_drive(relay_drive, 8'hA5);
		wt(8);
		io(1'b0, 32'h0, 8'h00, 9'h1A5);
		io(1'b1, 32'h1, 8'hFE, 9'h0);
		wt(2);
		chk_drive(relay_drive, 8'h00);
		io(1'b1, 32'h1, 8'h01, 9'h0);
		repeat (4) begin
			v = 8'($urandom);
			io(1'b1, 32'h0, ~v, 9'h0);
			io(1'b1, 32'h0, v, 9'h0);
			wt(2);
			chk_drive(relay_drive, v);
		end
		rst_n = 1'b0;
		wt(2);
		chk_drive(relay_drive, 8'h00);
		rst_n = 1'b1;
		io(1'b1, 32'h0, 8'hFF, 9'h0);
		wt(3);
		chk_drive(relay_drive, 8'h00);
		opto_in_n = 8'($urandom);
		wt(6);
		io(1'b0, 32'h1, 8'h00, {1'b1, opto_in_n});
		debounce_select_straps = 8'h0F;
		v = opto_in_n;
		wt(6);
		opto_in_n = ~v;
		wt(5);
		io(1'b0, 32'h1, 8'h00, {1'b1, ~v[7:4], v[3:0]});
		wt(20);
		io(1'b0, 32'h1, 8'h00, {1'b1, ~v});
		cfg(1'b0, 6'h00, 32'h0, {1'b1, 32'h00011234});
		cfg(1'b0, 6'h0B, 32'h0, {1'b1, 32'h00021234});
		cfg(1'b1, 6'h00, 32'hFFFFFFFF, 33'h0);
		cfg(1'b0, 6'h00, 32'h0, {1'b1, 32'h00011234});
		cfg(1'b1, 6'h06, 32'h00000104, 33'h0);
		base = 32'h104;
		cfg(1'b0, 6'h06, 32'h0, {1'b1, 32'h00000105});
		cfg(1'b1, 6'h0F, 32'h0000005A, 33'h0);
		cfg(1'b0, 6'h0F, 32'h0, {1'b1, 32'h0000005A});
		cfg(1'b0, 6'h01, 32'h0, {1'b1, 32'h0});
		io(1'b0, 32'h1, 8'h00, 9'h0);
		io(1'b0, 32'h106, 8'h00, 9'h0);
		io(1'b0, 32'h105, 8'h00, {1'b1, ~v});
		wt(4);
		chk(io_q.size(), 32'h0);
		close_out();
	end
endmodule
